// ==== rtl/spl_pkg.sv ====
// soft pin preset loader: shared constants, register map and preset layouts
// assumes a 32-bit ahb-lite register port and a 40 MHz control clock
package spl_pkg;

    // ------------------------------------------------------------------
    // register map (word index; byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [11:0] SPL_IDX_ENABLE   = 12'h0C00;  // section one enable
    localparam logic [11:0] SPL_IDX_FREQ_SEL = 12'h0C01;  // input/output preset choice
    localparam logic [11:0] SPL_IDX_SYS_REF  = 12'h0C02;  // system pll reference choice
    localparam logic [11:0] SPL_IDX_CONTROL  = 12'h0C10;  // reload trigger and load status

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int SPL_ENABLE_BIT   = 0;   // enable bit in the enable register
    localparam int SPL_OUT_SEL_LSB  = 4;   // output choice, bits 7:4
    localparam int SPL_IN_SEL_LSB   = 0;   // input choice, bits 3:0
    localparam int SPL_SEL_W        = 4;   // width of each choice field
    localparam int SPL_SYS_REF_W    = 2;   // width of the reference choice
    localparam int SPL_RELOAD_BIT   = 0;   // control: write 1 to rerun the load
    localparam int SPL_STAT_SOFT    = 1;   // control: pin was in soft state
    localparam int SPL_STAT_LOADED  = 2;   // control: presets were copied
    localparam int SPL_STAT_BUSY    = 3;   // control: load sequence running

    localparam logic        SPL_ENABLE_RST   = 1'b0;
    localparam logic [7:0]  SPL_FREQ_SEL_RST = 8'h00;
    localparam logic [1:0]  SPL_SYS_REF_RST  = 2'h0;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int          SPL_SETTLE_CYCLES = 3;      // fill the pin synchroniser
    localparam logic [1:0]  SPL_SETTLE_LAST   = 2'(SPL_SETTLE_CYCLES - 1);

    // ------------------------------------------------------------------
    // preset layouts
    // ------------------------------------------------------------------
    localparam int SPL_NUM_CHAN_DIV = 5;   // output channel dividers
    localparam int SPL_NUM_PROFILES = 4;   // reference profiles

    typedef struct packed {
        logic [47:0]                       free_run_tuning_word;
        logic [9:0]                        output_feedback_divider;
        logic [2:0]                        rf_stage_divider;
        logic [SPL_NUM_CHAN_DIV-1:0][9:0]  output_channel_dividers;
    } spl_out_preset_t;

    typedef struct packed {
        logic [39:0] ref_period;
        logic [19:0] ref_divider;
        logic [16:0] integer_feedback_divider;
        logic [22:0] feedback_fraction;
        logic [22:0] feedback_modulus;
    } spl_in_preset_t;

    // 12-bit system pll setting
    typedef struct packed {
        logic       ref_is_49m;        // 0: 24.576 MHz, 1: 49.152 MHz
        logic       crystal_resonator; // 1: resonator, 0: oscillator module
        logic       doubler_on;        // input doubler
        logic [8:0] n_div;             // feedback divide
    } spl_sys_pll_t;

    localparam spl_sys_pll_t SPL_SYS_PLL_PRESET [4] = '{
        '{1'b0, 1'b1, 1'b1, 9'h008},
        '{1'b1, 1'b1, 1'b1, 9'h008},
        '{1'b0, 1'b0, 1'b0, 9'h010},
        '{1'b1, 1'b0, 1'b0, 9'h008}
    };

    // load sequence
    typedef enum logic [1:0] {
        SPL_IDLE    = 2'b00,
        SPL_SETTLE  = 2'b01,
        SPL_FETCH   = 2'b11,
        SPL_CAPTURE = 2'b10
    } spl_state_t;

endpackage

// ==== rtl/spl_preset_rom.sv ====
// soft pin preset loader: preset rom with a registered read port
// assumes contents are given as a parameter; read data lag the address by one clock
`timescale 1ns/1ps
`default_nettype none

module spl_preset_rom #(
    parameter int                WIDTH = 8,
    parameter int                DEPTH = 16,
    parameter logic [WIDTH-1:0]  CONTENT [DEPTH] = '{default: '0}
) (
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    input  wire logic [$clog2(DEPTH)-1:0] addr,
    output logic      [WIDTH-1:0]         rdata
);

    // ------------------------------------------------------------------
    // registered read
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata <= '0;
        end else begin
            rdata <= CONTENT[addr];
        end
    end

endmodule

`default_nettype wire

// ==== rtl/spl_loader.sv ====
// soft pin preset loader: ahb-lite registers, pin sampling and preset copy
// assumes a single 40 MHz clock and a program-select pin from outside the domain
//
// How it works
// - enable bit low: selections ignored, nothing loaded
// - enable high, pin low at end of settle: load presets
// - pin high: whole section ignored, enable too
// - 256 translations from input and output choices
// - output choice loads tuning word and dividers
// - input choice loads four reference profiles
// - codes 00/01 select crystal, doubler, N 8
// - codes 10/11 select oscillator presets, twelve bits
`timescale 1ns/1ps
`default_nettype none

module spl_loader
    import spl_pkg::*;
#(
    parameter logic [$bits(spl_out_preset_t)-1:0] OUT_ROM [16] = '{default: '0},
    parameter logic [$bits(spl_in_preset_t)-1:0]  IN_ROM  [16] = '{default: '0}
) (
    input  wire logic                                   hclk,
    input  wire logic                                   hresetn,
    // ahb-lite slave
    input  wire logic                                   hsel,
    input  wire logic [31:0]                            haddr,
    input  wire logic [1:0]                             htrans,
    input  wire logic                                   hwrite,
    input  wire logic [2:0]                             hsize,
    input  wire logic                                   hready,
    input  wire logic [31:0]                            hwdata,
    output logic      [31:0]                            hrdata,
    output logic                                        hreadyout,
    output logic                                        hresp,
    // program-select pin, low means soft pin program
    input  wire logic                                   program_select_pin,
    // loaded configuration
    output spl_out_preset_t                             out_preset,
    output spl_in_preset_t [SPL_NUM_PROFILES-1:0]       ref_profiles,
    output spl_sys_pll_t                                sys_pll_cfg,
    output logic                                        load_done
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic                 enable;          // section one enable
    logic [7:0]           freq_sel;        // output and input choice
    logic [1:0]           sys_ref;         // system pll reference choice
    logic                 soft_mode;       // pin sampled low at end of last settle
    logic                 loaded;          // presets copied since reset
    logic                 start_pending;   // run once after reset release
    logic                 reload_req;      // software asked for a rerun
    logic [2:0]           pin_sync;        // three-stage pin synchroniser
    logic                 pin_low;         // filtered pin level, low = soft
    logic [1:0]           settle_cnt;      // synchroniser fill counter
    spl_state_t           state;           // load sequence state
    spl_state_t           next_state;      // next load sequence state
    logic [7:0]           load_sel;        // frozen choice during a load
    logic [1:0]           load_ref;        // frozen reference during a load
    logic [$bits(spl_out_preset_t)-1:0] out_rom_data;  // output preset word
    logic [$bits(spl_in_preset_t)-1:0]  in_rom_data;   // input preset word
    logic                 ap_write;        // latched write address phase
    logic [11:0]          ap_index;        // latched word index
    logic                 ap_valid;        // latched phase hit the address window

    // ------------------------------------------------------------------
    // ahb address decode
    // ------------------------------------------------------------------
    wire        bus_take   = hsel && hready && htrans[1];
    wire        in_window  = (haddr[31:14] == 18'h0_0000);
    wire [11:0] bus_index  = haddr[13:2];
    wire        hit_enable = (ap_index == SPL_IDX_ENABLE);
    wire        hit_sel    = (ap_index == SPL_IDX_FREQ_SEL);
    wire        hit_ref    = (ap_index == SPL_IDX_SYS_REF);
    wire        hit_ctrl   = (ap_index == SPL_IDX_CONTROL);
    wire        wr_cycle   = ap_valid && ap_write;
    wire        busy       = (state != SPL_IDLE);

    // read mux on the address phase, reserved bits forced to zero
    wire [7:0]  ctrl_view  = {4'h0, busy, loaded, soft_mode, 1'b0};
    wire [7:0]  read_mux   =
        (!in_window)                  ? 8'h00 :
        (bus_index == SPL_IDX_ENABLE)   ? {7'h00, enable} :
        (bus_index == SPL_IDX_FREQ_SEL) ? freq_sel :
        (bus_index == SPL_IDX_SYS_REF)  ? {6'h00, sys_ref} :
        (bus_index == SPL_IDX_CONTROL)  ? ctrl_view : 8'h00;

    // zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ------------------------------------------------------------------
    // address phase latch
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_write <= 1'b0;
            ap_index <= 12'h000;
            ap_valid <= 1'b0;
        end else if (hready) begin
            ap_write <= hwrite;
            ap_index <= bus_index;
            ap_valid <= bus_take && in_window;
        end
    end

    // read data registered at the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (bus_take && !hwrite) begin
            hrdata <= {24'h00_0000, read_mux};
        end
    end

    // ------------------------------------------------------------------
    // software registers, only defined bits stored
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable   <= SPL_ENABLE_RST;
            freq_sel <= SPL_FREQ_SEL_RST;
            sys_ref  <= SPL_SYS_REF_RST;
        end else if (wr_cycle) begin
            if (hit_enable) begin
                enable <= hwdata[SPL_ENABLE_BIT];
            end
            if (hit_sel) begin
                freq_sel <= hwdata[7:0];
            end
            if (hit_ref) begin
                sys_ref <= hwdata[SPL_SYS_REF_W-1:0];
            end
        end
    end

    // rerun request: set by a control write, cleared when a load starts
    wire reload_set = wr_cycle && hit_ctrl && hwdata[SPL_RELOAD_BIT];
    wire start_take = (state == SPL_IDLE) && (start_pending || reload_req);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reload_req    <= 1'b0;
            start_pending <= 1'b1;
        end else begin
            // a new request in the taking cycle wins
            reload_req    <= reload_set || (reload_req && !start_take);
            start_pending <= start_pending && !start_take;
        end
    end

    // ------------------------------------------------------------------
    // program-select pin synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_sync <= 3'b111;
        end else begin
            pin_sync <= {pin_sync[1:0], program_select_pin};
        end
    end

    // level counts once the second and third stages agree
    wire pin_agree = (pin_sync[1] == pin_sync[2]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_low <= 1'b0;
        end else if (pin_agree) begin
            pin_low <= !pin_sync[2];
        end
    end

    // ------------------------------------------------------------------
    // load sequence
    // ------------------------------------------------------------------
    wire settled   = (settle_cnt == SPL_SETTLE_LAST) && pin_agree && (pin_low == !pin_sync[2]);
    wire soft_go   = pin_low && enable;

    always_comb begin
        next_state = state;
        case (state)
            SPL_IDLE: begin
                if (start_take) begin
                    next_state = SPL_SETTLE;
                end
            end
            SPL_SETTLE: begin
                if (settled) begin
                    // hard pin program or disabled: nothing taken
                    next_state = soft_go ? SPL_FETCH : SPL_IDLE;
                end
            end
            SPL_FETCH: begin
                next_state = SPL_CAPTURE;
            end
            SPL_CAPTURE: begin
                next_state = SPL_IDLE;
            end
            default: begin
                next_state = SPL_IDLE;
            end
        endcase
    end

    // state, settle counter, frozen choice
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state      <= SPL_IDLE;
            settle_cnt <= 2'h0;
            load_sel   <= 8'h00;
            load_ref   <= 2'h0;
        end else begin
            state      <= next_state;
            settle_cnt <= (state == SPL_SETTLE && settle_cnt != SPL_SETTLE_LAST) ? settle_cnt + 2'h1 :
                          (state == SPL_SETTLE) ? settle_cnt : 2'h0;
            if (state == SPL_SETTLE && settled) begin
                load_sel <= freq_sel;
                load_ref <= sys_ref;
            end
        end
    end

    // pin state seen at the end of the settle phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            soft_mode <= 1'b0;
        end else if (state == SPL_SETTLE && settled) begin
            soft_mode <= pin_low;
        end
    end

    // ------------------------------------------------------------------
    // preset roms: 16 outputs by 16 inputs
    // ------------------------------------------------------------------
    spl_preset_rom #(
        .WIDTH   ($bits(spl_out_preset_t)),
        .DEPTH   (16),
        .CONTENT (OUT_ROM)
    ) u_out_rom (
        .hclk    (hclk),
        .hresetn (hresetn),
        .addr    (load_sel[SPL_OUT_SEL_LSB +: SPL_SEL_W]),
        .rdata   (out_rom_data)
    );

    spl_preset_rom #(
        .WIDTH   ($bits(spl_in_preset_t)),
        .DEPTH   (16),
        .CONTENT (IN_ROM)
    ) u_in_rom (
        .hclk    (hclk),
        .hresetn (hresetn),
        .addr    (load_sel[SPL_IN_SEL_LSB +: SPL_SEL_W]),
        .rdata   (in_rom_data)
    );

    // ------------------------------------------------------------------
    // configuration copy
    // ------------------------------------------------------------------
    wire do_copy = (state == SPL_CAPTURE);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_preset   <= '0;
            ref_profiles <= '0;
            sys_pll_cfg  <= SPL_SYS_PLL_PRESET[0];
            loaded       <= 1'b0;
            load_done    <= 1'b0;
        end else begin
            load_done <= do_copy;
            if (do_copy) begin
                out_preset   <= spl_out_preset_t'(out_rom_data);
                // same input preset into every reference profile
                ref_profiles <= {SPL_NUM_PROFILES{spl_in_preset_t'(in_rom_data)}};
                // takes effect downstream after the update strobe
                sys_pll_cfg  <= SPL_SYS_PLL_PRESET[load_ref];
                loaded       <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ==== dv/spl_loader_properties.sv ====
// spl loader checker: bus, preset and pin relations
// assumes binding onto spl_loader, one clock domain
`timescale 1ns/1ps
`default_nettype none

module spl_loader_properties
    import spl_pkg::*;
(
    input wire logic                                  hclk,
    input wire logic                                  hresetn,
    input wire logic                                  hsel,
    input wire logic [31:0]                           haddr,
    input wire logic [1:0]                            htrans,
    input wire logic                                  hwrite,
    input wire logic                                  hready,
    input wire logic [31:0]                           hwdata,
    input wire logic [31:0]                           hrdata,
    input wire logic                                  program_select_pin,
    input wire spl_out_preset_t                       out_preset,
    input wire spl_in_preset_t [SPL_NUM_PROFILES-1:0] ref_profiles,
    input wire spl_sys_pll_t                          sys_pll_cfg,
    input wire logic                                  load_done
);
    // ----------------
    // helper logic
    // ----------------
    wire        take  = hsel && hready && htrans[1]; // accepted address phase
    wire        at_en = haddr == 32'({SPL_IDX_ENABLE, 2'b00}); // enable register hit
    logic       wr_en_q;                             // enable write, data phase
    logic       rd_en_q;                             // enable read, data phase
    logic       en_shadow;                           // copy of the enable bit
    logic [3:0] hi_cnt;                              // pin-high cycles, saturating

    // enable shadow and pin-high counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_en_q   <= 1'b0;
            rd_en_q   <= 1'b0;
            en_shadow <= 1'b0;
            hi_cnt    <= 4'h0;
        end else begin
            wr_en_q <= take && hwrite && at_en;
            rd_en_q <= take && !hwrite && at_en;
            if (wr_en_q) en_shadow <= hwdata[0];
            if (!program_select_pin) hi_cnt <= 4'h0;
            else if (hi_cnt != 4'hF) hi_cnt <= hi_cnt + 4'h1;
        end
    end

    // ----------------
    // properties
    // ----------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_off; load_done |-> en_shadow; endproperty
    a_off: assert property (p_off)
        else $error("load while section disabled");
    property p_soft; load_done |-> $past(program_select_pin, 4) == 1'b0; endproperty
    a_soft: assert property (p_soft)
        else $error("load without soft pin state");
    property p_hard; hi_cnt == 4'hF |-> !load_done && $stable(out_preset); endproperty
    a_hard: assert property (p_hard)
        else $error("load while hard pin program");
    property p_out; $changed(out_preset) |-> load_done; endproperty
    a_out: assert property (p_out)
        else $error("output preset changed outside a load");
    property p_in; $changed(ref_profiles) |-> load_done; endproperty
    a_in: assert property (p_in)
        else $error("profiles changed outside a load");
    property p_same; ref_profiles[0] == ref_profiles[1] && ref_profiles[2] == ref_profiles[3]
        && ref_profiles[0] == ref_profiles[3]; endproperty
    a_same: assert property (p_same)
        else $error("reference profiles differ");
    property p_crystal_resonator; sys_pll_cfg.crystal_resonator |-> sys_pll_cfg.doubler_on
        && sys_pll_cfg.n_div == 9'h008; endproperty
    a_crystal_resonator: assert property (p_crystal_resonator)
        else $error("resonator setting wrong");
    property p_osc; !sys_pll_cfg.crystal_resonator |-> !sys_pll_cfg.doubler_on
        && sys_pll_cfg.n_div == (sys_pll_cfg.ref_is_49m ? 9'h008 : 9'h010); endproperty
    a_osc: assert property (p_osc)
        else $error("oscillator setting wrong");
    property p_rsv; rd_en_q |-> hrdata[31:1] == 31'h0000_0000; endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved enable bits not zero");

    c_load: cover property (load_done);
    c_hard: cover property (hi_cnt == 4'hF);
    c_osc: cover property (!sys_pll_cfg.crystal_resonator);
endmodule

bind spl_loader spl_loader_properties u_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .program_select_pin(program_select_pin), .out_preset(out_preset),
    .ref_profiles(ref_profiles), .sys_pll_cfg(sys_pll_cfg), .load_done(load_done)
);

`default_nettype wire

// ==== dv/spl_host_model.sv ====
// host software model: single-word ahb-lite master
// assumes hready is the loader's hreadyout
`timescale 1ns/1ps
`default_nettype none

module spl_host_model
    import spl_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    // idle bus at time zero
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0000_0000;
    end

    // one transfer; released lines show the inverse of their last value
    task automatic xfer(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        haddr  <= ~a;
        hwdata <= wr ? d : ~hwdata;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask

    // reference change followed by the external update strobe
    task automatic set_sys_ref(input logic [1:0] c);
        logic [31:0] q;
        xfer(1'b1, 32'({SPL_IDX_SYS_REF, 2'b00}), 32'(c), q);
        xfer(1'b1, 32'({12'h0C07, 2'b00}), 32'h0000_0001, q);
    endtask
endmodule

`default_nettype wire

// ==== dv/spl_loader_tb_top.sv ====
// soft pin preset loader testbench
// assumes the host model drives the bus and presets are bench-made
`timescale 1ns/1ps
`default_nettype none

module spl_loader_tb_top
    import spl_pkg::*;;
    typedef logic [$bits(spl_out_preset_t)-1:0] spl_orom_t [16];
    typedef logic [$bits(spl_in_preset_t)-1:0]  spl_irom_t [16];

    // distinct preset patterns per entry
    function automatic spl_orom_t mk_out();
        for (int i = 0; i < 16; i++) mk_out[i] = 111'({7{12'h0A5, 4'(i)}});
    endfunction
    function automatic spl_irom_t mk_in();
        for (int i = 0; i < 16; i++) mk_in[i] = 123'({8{4'(i), 12'h05A}});
    endfunction
    localparam spl_orom_t OROM = mk_out();
    localparam spl_irom_t IROM = mk_in();

    logic                                  hclk = 1'b0;
    logic                                  hresetn = 1'b0;
    logic                                  program_select_pin = 1'b0;
    logic                                  hsel;
    logic [31:0]                           haddr;
    logic [1:0]                            htrans;
    logic                                  hwrite;
    logic [2:0]                            hsize;
    logic [31:0]                           hwdata;
    logic [31:0]                           hrdata;
    logic                                  hreadyout;
    logic                                  hresp;
    spl_out_preset_t                       out_preset;
    spl_in_preset_t [SPL_NUM_PROFILES-1:0] ref_profiles;
    spl_sys_pll_t                          sys_pll_cfg;
    logic                                  load_done;
    int                                    num_errors = 0;
    int                                    n_checks = 0;
    int                                    cyc = 0;

    always #12.5 hclk = ~hclk;

    spl_host_model host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    spl_loader #(.OUT_ROM(OROM), .IN_ROM(IROM)) dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .program_select_pin(program_select_pin), .out_preset(out_preset),
        .ref_profiles(ref_profiles), .sys_pll_cfg(sys_pll_cfg), .load_done(load_done));

    // ----------------
    // helpers
    // ----------------
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(string nm, logic [127:0] got, logic [127:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // system pll setting expected per reference code
    function automatic spl_sys_pll_t exp_pll(logic [1:0] c);
        return {c[0], !c[1], !c[1], (c == 2'h2) ? 9'h010 : 9'h008};
    endfunction

    task automatic wr(logic [11:0] idx, logic [7:0] d);
        logic [31:0] q;
        host.xfer(1'b1, 32'({idx, 2'b00}), 32'(d), q);
    endtask

    task automatic rd_chk(string nm, logic [11:0] idx, logic [7:0] exp);
        logic [31:0] q;
        host.xfer(1'b0, 32'({idx, 2'b00}), 32'h0000_0000, q);
        check(nm, 128'(q), 128'(exp));
    endtask

    // rerun the load, judge completion and status
    task automatic reload(logic exp_ld, logic [7:0] exp_st);
        logic seen = 1'b0;
        wr(SPL_IDX_CONTROL, 8'h01);
        repeat (30) begin
            @(posedge hclk);
            if (load_done === 1'b1) seen = 1'b1;
        end
        check("load_done", 128'(seen), 128'(exp_ld));
        rd_chk("status", SPL_IDX_CONTROL, exp_st);
    endtask

    // ----------------
    // scenarios
    // ----------------
    task automatic t_reset();
        rd_chk("enable", SPL_IDX_ENABLE, 8'h00);
        rd_chk("freq_sel", SPL_IDX_FREQ_SEL, 8'h00);
        rd_chk("sys_ref", SPL_IDX_SYS_REF, 8'h00);
        check("pll", 128'(sys_pll_cfg), 128'(exp_pll(2'h0)));
    endtask

    task automatic t_disabled();
        wr(SPL_IDX_FREQ_SEL, 8'h5A);
        host.set_sys_ref(2'h3);
        reload(1'b0, 8'h02);
        check("out", 128'(out_preset), 128'h0);
        check("pll", 128'(sys_pll_cfg), 128'(exp_pll(2'h0)));
    endtask

    task automatic t_loads();
        logic [3:0] o, i;
        wr(SPL_IDX_ENABLE, 8'h01);
        for (int c = 0; c < 4; c++) begin
            o = 4'(c * 5);
            i = 4'(15 - c * 5);
            wr(SPL_IDX_FREQ_SEL, {o, i});
            host.set_sys_ref(2'(c));
            reload(1'b1, 8'h06);
            check("out", 128'(out_preset), 128'(OROM[o]));
            for (int k = 0; k < 4; k++) check("prof", 128'(ref_profiles[k]), 128'(IROM[i]));
            check("pll", 128'(sys_pll_cfg), 128'(exp_pll(2'(c))));
        end
    endtask

    task automatic t_hard();
        @(posedge hclk);
        program_select_pin <= 1'b1;
        repeat (12) @(posedge hclk);
        wr(SPL_IDX_FREQ_SEL, 8'h33);
        host.set_sys_ref(2'h1);
        reload(1'b0, 8'h04);
        check("out", 128'(out_preset), 128'(OROM[15]));
        check("pll", 128'(sys_pll_cfg), 128'(exp_pll(2'h3)));
        program_select_pin <= 1'b0;
        repeat (12) @(posedge hclk);
    endtask

    task automatic t_rsv();
        wr(SPL_IDX_ENABLE, 8'hFF);
        wr(SPL_IDX_SYS_REF, 8'hFF);
        wr(12'h0C40, 8'hFF);
        rd_chk("enable", SPL_IDX_ENABLE, 8'h01);
        rd_chk("sys_ref", SPL_IDX_SYS_REF, 8'h03);
        rd_chk("unmapped", 12'h0C40, 8'h00);
        check("resp", 128'({hreadyout, hresp}), 128'h2);
    endtask

    // hang guard
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 4000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_disabled();
        t_loads();
        t_hard();
        t_rsv();
        tally_and_finish();
    end
endmodule

`default_nettype wire
